// [core/sfr_pkg.sv]
// Purpose: Shared constants and types for the core special-register block
// Assumes: One 10 MHz clock, 8-bit data memory words
// Notes: Offsets are data memory addresses of the special-purpose area
package sfr_pkg;
  // Special register offsets
  localparam logic [7:0] OFS_IND0 = 8'h00;
  localparam logic [7:0] OFS_PTR0 = 8'h01;
  localparam logic [7:0] OFS_IND1 = 8'h02;
  localparam logic [7:0] OFS_PTR1 = 8'h03;
  localparam logic [7:0] OFS_BANK = 8'h04;
  localparam logic [7:0] OFS_ACC = 8'h05;
  localparam logic [7:0] OFS_PCL = 8'h06;
  localparam logic [7:0] OFS_TABLE_POINTER = 8'h07;
  localparam logic [7:0] OFS_TABLE_HIGH_BYTE = 8'h08;
  localparam logic [7:0] OFS_WDDIV = 8'h09;
  localparam logic [7:0] OFS_STATUS = 8'h0a;
  localparam logic [7:0] OFS_IRQ0 = 8'h0b;
  localparam logic [7:0] OFS_TMR_FIRST = 8'h0c;
  localparam logic [7:0] OFS_TMR_LAST = 8'h11;
  localparam logic [7:0] OFS_PORT_FIRST = 8'h12;
  localparam logic [7:0] OFS_PORT_LAST = 8'h1b;
  localparam logic [7:0] OFS_IRQ1 = 8'h1e;
  localparam logic [7:0] OFS_GP_BASE = 8'h30;
  // Status field positions
  localparam int ST_C = 0;
  localparam int ST_AC = 1;
  localparam int ST_Z = 2;
  localparam int ST_OV = 3;
  localparam int ST_PDF = 4;
  localparam int ST_TO = 5;
  // Global enable position in first interrupt control register
  localparam int IRQ_EMI = 0;
  // Reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_PORT = 8'hff;
  localparam logic [2:0] RST_BANK = 3'h0;
  localparam logic [2:0] RST_WDDIV = 3'h7;
  // Watchdog counter width, overflow after 2**WDT_BITS prescaled ticks
  localparam int WDT_BITS = 8;
  // ALU operations
  typedef enum logic [2:0] {
    ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC, ALU_LOGIC, ALU_RLC, ALU_RRC
  } alu_op_t;
endpackage

// [core/alu_flags.sv]
// Purpose: Arithmetic result and status flag generation
// Assumes: Logic results are formed by the core and passed in op_a
// Notes: Purely combinational, upd marks which flags change
`timescale 1ns/1ns
module alu_flags import sfr_pkg::*; (
  input wire alu_op_t op,
  input wire logic [7:0] op_a,
  input wire logic [7:0] op_b,
  input wire logic carry_in,
  output logic [7:0] result,
  output logic [3:0] flags,
  output logic [3:0] upd
);
  logic [7:0] bb; // Second operand, inverted for subtraction
  logic cin; // Carry into bit zero
  logic [4:0] low; // Low nibble sum
  logic [7:0] low7; // Sum of seven low bits
  logic [8:0] full; // Whole sum

  // Adder and flag logic
  always_comb begin
    bb = (op == ALU_SUB || op == ALU_SBC) ? ~op_b : op_b;
    cin = (op == ALU_SUB) || ((op == ALU_ADC || op == ALU_SBC) && carry_in);
    low = {1'b0, op_a[3:0]} + {1'b0, bb[3:0]} + {4'h0, cin};
    low7 = {1'b0, op_a[6:0]} + {1'b0, bb[6:0]} + {7'h00, cin};
    full = {1'b0, op_a} + {1'b0, bb} + {8'h00, cin};
    result = full[7:0];
    flags = 4'h0;
    upd = 4'hf;
    flags[ST_C] = full[8]; // R13
    flags[ST_AC] = low[4]; // R14
    flags[ST_OV] = low7[7] ^ full[8]; // R16
    unique case (op)
      ALU_LOGIC: begin
        result = op_a;
        upd = 4'h0;
        upd[ST_Z] = 1'b1;
      end
      ALU_RLC: begin
        result = {op_a[6:0], carry_in};
        flags[ST_C] = op_a[7]; // R13
        upd = 4'h0;
        upd[ST_C] = 1'b1;
      end
      ALU_RRC: begin
        result = {carry_in, op_a[7:1]};
        flags[ST_C] = op_a[0]; // R13
        upd = 4'h0;
        upd[ST_C] = 1'b1;
      end
      default: begin
      end
    endcase
    flags[ST_Z] = (result == 8'h00); // R15
  end
endmodule

// [core/wdt_timer.sv]
// Purpose: Watchdog prescaler and overflow counter
// Assumes: Watchdog clock source is the system clock
// Notes: Ratio is 2**div, from 1 to 128
`timescale 1ns/1ns
module wdt_timer import sfr_pkg::*; (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [2:0] div,
  input wire logic clear,
  output logic timeout
);
  typedef struct packed {
    logic [6:0] pre; // Prescaler count
    logic [WDT_BITS-1:0] cnt; // Watchdog count
    logic out; // Timeout pulse
  } wdt_state_t;

  wdt_state_t st_ff;
  wdt_state_t nxt_st;
  logic [6:0] mask; // Prescaler terminal mask

  // Prescale, count and flag overflow
  always_comb begin
    nxt_st = st_ff;
    mask = 7'((8'h01 << div) - 8'h01); // R10
    nxt_st.out = 1'b0;
    nxt_st.pre = ((st_ff.pre & mask) == mask) ? 7'h00 : st_ff.pre + 7'h01;
    if (clear) begin
      nxt_st.pre = 7'h00;
      nxt_st.cnt = '0;
    end else if ((st_ff.pre & mask) == mask) begin
      nxt_st.cnt = st_ff.cnt + 1'b1;
      nxt_st.out = &st_ff.cnt; // R11
    end
  end

  // State register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign timeout = st_ff.out;
endmodule

// [core/core_sfr.sv]
// Purpose: Core special-function registers of an 8-bit microcontroller
// Assumes: Core issues one-cycle strobes; program memory answers in the same cycle
// Notes: Timer counting and port pin drivers live elsewhere
// Summary of operation
// R1 - Bank register picks general data bank
// R2 - First indirect pair always reaches bank zero
// R3 - Reset zeroes bank, except watchdog in halt
// R4 - Special registers reachable from any bank
// R5 - Direct addressing always reaches bank zero
// R6 - Register moves and ALU results use accumulator
// R7 - Low counter write jumps within page
// R8 - Jump by low counter write adds dummy
// R9 - Table read fills high register, low elsewhere
// R10 - Three divider bits set ratio 1 to 128
// R11 - Watchdog overflow resets unless cleared first
// R12 - Status writes leave halt and expiry flags
// R13 - Carry from add, no-borrow, or rotate
// R14 - Nibble carry from low nibble
// R15 - Zero flag marks zero results
// R16 - Overflow is carry in xor out
// R17 - Halt sets halt flag, clear-watchdog clears
// R18 - Expiry flag set by timeout, cleared otherwise
// R19 - Status is never stacked by hardware
// R20 - Global enable cleared on entry, set on return
// R21 - Direction bit one means input
// R22 - Two timers as low, high and setup
// R23 - Unused special locations read zero
// R24 - Indirect to indirect ports reads zero
// R25 - Bank register holds three value bits
//
// Added by the designer: the strobed register port and the register addresses.
`timescale 1ns/1ns
module core_sfr import sfr_pkg::*; (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rd_data,
  output logic [10:0] dm_addr,
  output logic dm_wr,
  output logic dm_rd,
  output logic [7:0] dm_wdata,
  input wire logic [7:0] dm_rdata,
  input wire logic op_valid,
  input wire alu_op_t op,
  input wire logic [7:0] op_a,
  input wire logic [7:0] op_b,
  output logic [7:0] acc_out,
  input wire logic [3:0] pc_page,
  input wire logic [7:0] pc_low,
  output logic pc_jump,
  output logic [7:0] jump_low,
  output logic dummy_cycle,
  input wire logic tbl_rd,
  output logic [11:0] pm_addr,
  input wire logic [15:0] pm_word,
  output logic tbl_low_valid,
  output logic [7:0] tbl_low,
  input wire logic halt_instr,
  input wire logic watchdog_clear_instr,
  input wire logic irq_entry,
  input wire logic irq_return_instr,
  output logic global_irq_enable,
  output logic wdt_reset,
  input wire logic [3:0][7:0] port_pin,
  output logic [3:0][7:0] port_out,
  output logic [3:0][7:0] port_oe
);
  typedef struct packed {
    logic [7:0] pointer_zero; // First memory pointer
    logic [7:0] pointer_one; // Second memory pointer
    logic [2:0] bank_select; // Bank value bits
    logic [7:0] accumulator; // Accumulator
    logic [7:0] prog_counter_low; // Last jump target
    logic [7:0] table_pointer; // Table pointer
    logic [7:0] table_high_byte; // Table high byte
    logic [2:0] watchdog_divider_select; // Divider bits
    logic [5:0] status_flags; // Status bits
    logic [7:0] irq_control_first; // Interrupt control 0
    logic [7:0] irq_control_second; // Interrupt control 1
    logic [5:0][7:0] timer_regs; // Count pairs and setup
    logic [3:0][7:0] port_data; // Port output latches
    logic [3:0][7:0] port_dir; // Port directions
    logic [3:0][7:0] pin_meta; // First sync stage
    logic [3:0][7:0] pin_sync; // Second sync stage
    logic [7:0] rd_val; // Registered read value
    logic rd_gp; // Read answered by data memory
    logic jump; // Jump pulse
    logic dummy; // Dummy cycle pulse
    logic tbl_valid; // Table low byte pulse
    logic [7:0] tbl_lo; // Table low byte
    logic wdt_rst; // Watchdog reset pulse
  } sfr_state_t;

  // Reset image of the state
  function automatic sfr_state_t reset_state();
    sfr_state_t s;
    s = '0;
    s.bank_select = RST_BANK;
    s.watchdog_divider_select = RST_WDDIV;
    s.port_data = {4{RST_PORT}};
    s.port_dir = {4{RST_PORT}};
    return s;
  endfunction

  sfr_state_t st_ff;
  sfr_state_t nxt_st;
  logic [7:0] alu_res; // ALU result
  logic [3:0] alu_flg; // ALU flags
  logic [3:0] alu_upd; // Flags to update
  logic wdt_to; // Watchdog overflow
  logic [2:0] eff_bank; // Resolved bank
  logic [7:0] eff_low; // Resolved offset
  logic via_ind; // Access through an indirect port
  logic is_sfr; // Resolved into special area
  logic [1:0] pidx; // Port index
  logic pdir; // Port direction register addressed

  alu_flags u_alu (
    .op(op),
    .op_a(op_a),
    .op_b(op_b),
    .carry_in(st_ff.status_flags[ST_C]),
    .result(alu_res),
    .flags(alu_flg),
    .upd(alu_upd)
  );

  wdt_timer u_wdt (
    .ref_clk(ref_clk),
    .rst(rst),
    .div(st_ff.watchdog_divider_select),
    .clear(watchdog_clear_instr),
    .timeout(wdt_to)
  );

  // Address resolution through pointers and bank
  always_comb begin
    eff_bank = 3'h0; // R5
    eff_low = addr;
    via_ind = 1'b0;
    if (addr == OFS_IND0) begin
      eff_low = st_ff.pointer_zero; // R2
      via_ind = 1'b1;
    end else if (addr == OFS_IND1) begin
      eff_bank = st_ff.bank_select; // R1
      eff_low = st_ff.pointer_one;
      via_ind = 1'b1;
    end
    is_sfr = eff_low < OFS_GP_BASE; // R4
    pidx = (eff_low[3:1] == 3'h1) ? 2'h0 : 2'(eff_low[3:1] - 3'h2); // A, C, D, E in slots 0 to 3
    pdir = eff_low[0];
  end

  // Data memory requests for general purpose locations
  always_comb begin
    dm_addr = {is_sfr ? 3'h0 : eff_bank, eff_low};
    dm_wr = wr_en && !is_sfr;
    dm_rd = rd_en && !is_sfr;
    dm_wdata = wr_data;
  end

  // Next state: software access then hardware events
  always_comb begin
    nxt_st = st_ff;
    nxt_st.pin_meta = port_pin;
    nxt_st.pin_sync = st_ff.pin_meta;
    nxt_st.jump = 1'b0;
    nxt_st.dummy = st_ff.jump; // R8
    nxt_st.tbl_valid = 1'b0;
    nxt_st.wdt_rst = 1'b0;
    nxt_st.rd_gp = rd_en && !is_sfr;
    nxt_st.rd_val = 8'h00;
    // Register reads, unused and indirect self reads give zero
    if (rd_en && is_sfr && !(via_ind && (eff_low == OFS_IND0 || eff_low == OFS_IND1))) begin
      unique case (eff_low)
        OFS_PTR0: nxt_st.rd_val = st_ff.pointer_zero;
        OFS_PTR1: nxt_st.rd_val = st_ff.pointer_one;
        OFS_BANK: nxt_st.rd_val = {5'h00, st_ff.bank_select}; // R25
        OFS_ACC: nxt_st.rd_val = st_ff.accumulator;
        OFS_PCL: nxt_st.rd_val = pc_low;
        OFS_TABLE_POINTER: nxt_st.rd_val = st_ff.table_pointer;
        OFS_TABLE_HIGH_BYTE: nxt_st.rd_val = st_ff.table_high_byte;
        OFS_WDDIV: nxt_st.rd_val = {5'h00, st_ff.watchdog_divider_select};
        OFS_STATUS: nxt_st.rd_val = {2'h0, st_ff.status_flags};
        OFS_IRQ0: nxt_st.rd_val = st_ff.irq_control_first;
        OFS_IRQ1: nxt_st.rd_val = st_ff.irq_control_second;
        default: begin
          if (eff_low >= OFS_TMR_FIRST && eff_low <= OFS_TMR_LAST) begin
            nxt_st.rd_val = st_ff.timer_regs[3'(eff_low - OFS_TMR_FIRST)]; // R22
          end else if (eff_low >= OFS_PORT_FIRST && eff_low <= OFS_PORT_LAST
                       && !(eff_low[3:1] == 3'h2)) begin
            // Input pins read the pin, outputs read the latch
            if (pdir) begin
              nxt_st.rd_val = st_ff.port_dir[pidx];
            end else begin
              nxt_st.rd_val = (st_ff.port_dir[pidx] & st_ff.pin_sync[pidx])
                | (~st_ff.port_dir[pidx] & st_ff.port_data[pidx]);
            end
          end else begin
            nxt_st.rd_val = 8'h00; // R23
          end
        end
      endcase
    end
    // Register writes, indirect self writes do nothing
    if (wr_en && is_sfr && !(via_ind && (eff_low == OFS_IND0 || eff_low == OFS_IND1))) begin // R24
      unique case (eff_low)
        OFS_PTR0: nxt_st.pointer_zero = wr_data;
        OFS_PTR1: nxt_st.pointer_one = wr_data;
        OFS_BANK: nxt_st.bank_select = wr_data[2:0]; // R25
        OFS_ACC: nxt_st.accumulator = wr_data; // R6
        OFS_PCL: begin
          nxt_st.prog_counter_low = wr_data; // R7
          nxt_st.jump = 1'b1; // R8
        end
        OFS_TABLE_POINTER: nxt_st.table_pointer = wr_data;
        OFS_WDDIV: nxt_st.watchdog_divider_select = wr_data[2:0]; // R10
        OFS_STATUS: nxt_st.status_flags[3:0] = wr_data[3:0]; // R12
        OFS_IRQ0: nxt_st.irq_control_first = wr_data;
        OFS_IRQ1: nxt_st.irq_control_second = wr_data;
        default: begin
          if (eff_low >= OFS_TMR_FIRST && eff_low <= OFS_TMR_LAST) begin
            nxt_st.timer_regs[3'(eff_low - OFS_TMR_FIRST)] = wr_data; // R22
          end else if (eff_low >= OFS_PORT_FIRST && eff_low <= OFS_PORT_LAST
                       && !(eff_low[3:1] == 3'h2)) begin
            if (pdir) begin
              nxt_st.port_dir[pidx] = wr_data; // R21
            end else begin
              nxt_st.port_data[pidx] = wr_data;
            end
          end
        end
      endcase
    end
    // ALU result into accumulator and flags
    if (op_valid) begin
      nxt_st.accumulator = alu_res; // R6
      for (int i = 0; i < 4; i++) begin
        if (alu_upd[i]) begin
          nxt_st.status_flags[i] = alu_flg[i]; // R13
        end
      end
    end
    // Table read through program memory
    if (tbl_rd) begin
      nxt_st.table_high_byte = pm_word[15:8]; // R9
      nxt_st.tbl_lo = pm_word[7:0];
      nxt_st.tbl_valid = 1'b1;
    end
    // Global enable, return sets and wins over entry
    if (irq_entry) begin
      nxt_st.irq_control_first[IRQ_EMI] = 1'b0; // R20
    end
    if (irq_return_instr) begin
      nxt_st.irq_control_first[IRQ_EMI] = 1'b1; // R20
    end
    // Halt and watchdog clear flags, hardware wins over writes
    if (halt_instr) begin
      nxt_st.status_flags[ST_PDF] = 1'b1; // R17
      nxt_st.status_flags[ST_TO] = 1'b0; // R18
    end
    if (watchdog_clear_instr) begin
      nxt_st.status_flags[ST_PDF] = 1'b0; // R17
      nxt_st.status_flags[ST_TO] = 1'b0; // R18
    end
    // Watchdog reset restores defaults, bank kept in power down
    if (wdt_to) begin
      nxt_st = reset_state(); // R11
      nxt_st.pin_meta = port_pin;
      nxt_st.pin_sync = st_ff.pin_meta;
      nxt_st.bank_select = st_ff.status_flags[ST_PDF] ? st_ff.bank_select : RST_BANK; // R3
      nxt_st.status_flags[ST_PDF] = st_ff.status_flags[ST_PDF];
      nxt_st.status_flags[ST_TO] = 1'b1; // R18
      nxt_st.wdt_rst = 1'b1;
    end
  end

  // State register, power-up reset clears all flags
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_ff <= reset_state(); // R3
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs, status never leaves the block for stacking
  assign rd_data = st_ff.rd_gp ? dm_rdata : st_ff.rd_val; // R19
  assign acc_out = st_ff.accumulator;
  assign pc_jump = st_ff.jump;
  assign jump_low = st_ff.prog_counter_low; // R7
  assign dummy_cycle = st_ff.dummy;
  assign pm_addr = {pc_page, st_ff.table_pointer}; // R9
  assign tbl_low_valid = st_ff.tbl_valid;
  assign tbl_low = st_ff.tbl_lo;
  assign global_irq_enable = st_ff.irq_control_first[IRQ_EMI];
  assign wdt_reset = st_ff.wdt_rst;
  assign port_out = st_ff.port_data;
  assign port_oe = ~st_ff.port_dir; // R21

  property p_bank_reset;
    @(posedge ref_clk) disable iff (rst)
      wdt_to && !st_ff.status_flags[ST_PDF] |=> st_ff.bank_select == 3'h0;
  endproperty
  a_bank_reset: assert property (p_bank_reset) else $error("bank not zeroed"); // R3

  property p_bank_keep;
    @(posedge ref_clk) disable iff (rst)
      wdt_to && st_ff.status_flags[ST_PDF] |=> $stable(st_ff.bank_select);
  endproperty
  a_bank_keep: assert property (p_bank_keep) else $error("bank lost in halt"); // R3

  property p_ind0_bank;
    @(posedge ref_clk) disable iff (rst)
      (wr_en || rd_en) && addr == OFS_IND0 |-> dm_addr[10:8] == 3'h0;
  endproperty
  a_ind0_bank: assert property (p_ind0_bank) else $error("pointer zero left bank 0"); // R2

  property p_direct_bank;
    @(posedge ref_clk) disable iff (rst)
      wr_en && addr >= OFS_GP_BASE |-> dm_wr && dm_addr == {3'h0, addr};
  endproperty
  a_direct_bank: assert property (p_direct_bank) else $error("direct not bank 0"); // R5

  property p_jump_dummy;
    @(posedge ref_clk) disable iff (rst)
      wr_en && addr == OFS_PCL && !wdt_to |=> pc_jump && jump_low == $past(wr_data)
        ##1 dummy_cycle && !pc_jump;
  endproperty
  a_jump_dummy: assert property (p_jump_dummy) else $error("jump or dummy missing"); // R8

  property p_status_keep;
    @(posedge ref_clk) disable iff (rst)
      wr_en && addr == OFS_STATUS && !halt_instr && !watchdog_clear_instr && !wdt_to
        |=> $stable(st_ff.status_flags[5:4]);
  endproperty
  a_status_keep: assert property (p_status_keep) else $error("status write hit flags"); // R12

  property p_halt;
    @(posedge ref_clk) disable iff (rst)
      halt_instr && !watchdog_clear_instr && !wdt_to
        |=> st_ff.status_flags[ST_PDF] && !st_ff.status_flags[ST_TO];
  endproperty
  a_halt: assert property (p_halt) else $error("halt flags wrong"); // R17

  property p_emi;
    @(posedge ref_clk) disable iff (rst)
      irq_entry && !irq_return_instr && !wdt_to |=> !global_irq_enable;
  endproperty
  a_emi: assert property (p_emi) else $error("enable not cleared"); // R20

  property p_acc;
    @(posedge ref_clk) disable iff (rst)
      op_valid && !wdt_to |=> acc_out == $past(alu_res);
  endproperty
  a_acc: assert property (p_acc) else $error("accumulator missed result"); // R6

  property p_cov_jump;
    @(posedge ref_clk) disable iff (rst) pc_jump ##1 dummy_cycle;
  endproperty
  c_cov_jump: cover property (p_cov_jump);

  property p_cov_wdt;
    @(posedge ref_clk) disable iff (rst) wdt_to ##1 wdt_reset;
  endproperty
  c_cov_wdt: cover property (p_cov_wdt);

  property p_cov_ind1;
    @(posedge ref_clk) disable iff (rst) rd_en && addr == OFS_IND1 && st_ff.bank_select != 3'h0;
  endproperty
  c_cov_ind1: cover property (p_cov_ind1);
endmodule

// [verif/tb_top.sv]
// Purpose: Self-checking bench for the core special-register block
// Assumes: Register port with one-cycle strobes, read data one cycle later
// Notes: Watchdog divider set to zero so an overflow lands within a few hundred cycles
`timescale 1ns/1ns
module tb_top import sfr_pkg::*;;
  // Compare, count and report at once
  `define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, got, exp); end end
  logic ref_clk = 1'b0; // System clock
  logic rst = 1'b1; // Power-up reset
  logic [7:0] addr = 8'h00, wr_data = 8'h00, dm_rdata = 8'h00, op_a = 8'h00, op_b = 8'h00;
  logic wr_en = 1'b0, rd_en = 1'b0, op_valid = 1'b0, tbl_rd = 1'b0, halt_instr = 1'b0;
  logic watchdog_clear_instr = 1'b0, irq_entry = 1'b0, irq_return_instr = 1'b0;
  alu_op_t op = ALU_ADD; // ALU operation
  logic [3:0] pc_page = 4'h0; // Upper counter bits
  logic [7:0] pc_low = 8'h00; // Current counter low byte
  logic [15:0] pm_word = 16'h0000; // Program word
  logic [3:0][7:0] port_pin = '0; // Pin levels
  logic [7:0] rd_data, acc_out, jump_low, tbl_low, rv;
  logic [10:0] dm_addr;
  logic dm_wr, dm_rd, pc_jump, dummy_cycle, tbl_low_valid, global_irq_enable, wdt_reset;
  logic [7:0] dm_wdata;
  logic [11:0] pm_addr;
  logic [3:0][7:0] port_out, port_oe;
  int n_mismatch = 0, checks_done = 0, cycles = 0;
  core_sfr dut (.ref_clk(ref_clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .dm_addr(dm_addr), .dm_wr(dm_wr), .dm_rd(dm_rd),
    .dm_wdata(dm_wdata), .dm_rdata(dm_rdata), .op_valid(op_valid), .op(op), .op_a(op_a),
    .op_b(op_b), .acc_out(acc_out), .pc_page(pc_page), .pc_low(pc_low), .pc_jump(pc_jump),
    .jump_low(jump_low), .dummy_cycle(dummy_cycle), .tbl_rd(tbl_rd), .pm_addr(pm_addr),
    .pm_word(pm_word), .tbl_low_valid(tbl_low_valid), .tbl_low(tbl_low),
    .halt_instr(halt_instr), .watchdog_clear_instr(watchdog_clear_instr),
    .irq_entry(irq_entry), .irq_return_instr(irq_return_instr),
    .global_irq_enable(global_irq_enable), .wdt_reset(wdt_reset), .port_pin(port_pin),
    .port_out(port_out), .port_oe(port_oe));
  // Clock, 100 ns period
  always #50 ref_clk = ~ref_clk;
  // Hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      test_done();
    end
  end
  // Closing report
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // One-cycle register write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask
  // One-cycle read, data sampled in the following cycle
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1 d = rd_data;
  endtask
  // Read with expected value
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    rd(a, rv);
    `CHK(rv, e)
  endtask
  // Data memory read, checks the outgoing RAM address
  task automatic dmr(input logic [7:0] a, input logic [10:0] e);
    @(posedge ref_clk);
    addr <= a;
    rd_en <= 1'b1;
    dm_rdata <= 8'h5a;
    #1 `CHK({dm_rd, dm_addr}, {1'b1, e})
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1 `CHK(rd_data, 8'h5a)
  endtask
  // ALU operation into the accumulator
  task automatic alu(input alu_op_t o, input logic [7:0] a, input logic [7:0] b,
                     input logic [7:0] e, input logic [7:0] st);
    @(posedge ref_clk);
    op <= o;
    op_a <= a;
    op_b <= b;
    op_valid <= 1'b1;
    @(posedge ref_clk);
    op_valid <= 1'b0;
    #1 `CHK(acc_out, e)
    rdc(OFS_STATUS, st);
  endtask
  // Wait for the watchdog reset pulse and look at it while it stands
  task automatic wdt_wait();
    repeat (400) begin
      @(posedge ref_clk);
      #1;
      if (wdt_reset === 1'b1) break;
    end
    `CHK(wdt_reset, 1'b1)
  endtask
  // Main sequence
  initial begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    rdc(OFS_BANK, 8'h00);
    rdc(OFS_WDDIV, 8'h07);
    `CHK({port_oe[0], port_out[0]}, 16'h00ff)
    $display("test reset done");
    wr(OFS_BANK, 8'h0a);
    rdc(OFS_BANK, 8'h02);
    wr(OFS_PTR1, 8'h40);
    wr(OFS_PTR0, 8'h41);
    dmr(OFS_IND1, 11'h240);
    dmr(OFS_IND0, 11'h041);
    dmr(8'h40, 11'h040);
    @(posedge ref_clk);
    addr <= 8'h45;
    wr_data <= 8'h33;
    wr_en <= 1'b1;
    #1 `CHK({dm_wr, dm_addr, dm_wdata}, {1'b1, 11'h045, 8'h33})
    @(posedge ref_clk);
    wr_en <= 1'b0;
    wr(8'h0d, 8'h9a);
    rdc(8'h0d, 8'h9a);
    rdc(OFS_PTR1, 8'h40);
    wr(OFS_PTR0, OFS_IND0);
    wr(OFS_IND0, 8'h11);
    rdc(OFS_IND0, 8'h00);
    wr(8'h14, 8'h55);
    rdc(8'h14, 8'h00);
    $display("test banks done");
    wr(OFS_PCL, 8'h3c);
    #1 `CHK({pc_jump, jump_low}, {1'b1, 8'h3c})
    @(posedge ref_clk);
    #1 `CHK({pc_jump, dummy_cycle}, 2'b01)
    wr(OFS_TABLE_POINTER, 8'h12);
    @(posedge ref_clk);
    tbl_rd <= 1'b1;
    pc_page <= 4'h3;
    pm_word <= 16'habcd;
    #1 `CHK(pm_addr, 12'h312)
    @(posedge ref_clk);
    tbl_rd <= 1'b0;
    #1 `CHK({tbl_low_valid, tbl_low}, {1'b1, 8'hcd})
    wr(OFS_TABLE_HIGH_BYTE, 8'h77);
    rdc(OFS_TABLE_HIGH_BYTE, 8'hab);
    $display("test jump and table done");
    alu(ALU_ADD, 8'h7f, 8'h01, 8'h80, 8'h0a);
    alu(ALU_SUB, 8'h05, 8'h05, 8'h00, 8'h07);
    alu(ALU_ADD, 8'hff, 8'h01, 8'h00, 8'h07);
    alu(ALU_ADD, 8'h80, 8'h80, 8'h00, 8'h0d);
    alu(ALU_RLC, 8'h81, 8'h00, 8'h03, 8'h0d);
    alu(ALU_LOGIC, 8'h5a, 8'h00, 8'h5a, 8'h09);
    alu(ALU_RRC, 8'h02, 8'h00, 8'h81, 8'h08);
    alu(ALU_SBC, 8'h05, 8'h01, 8'h03, 8'h03);
    wr(OFS_STATUS, 8'hf0);
    rdc(OFS_STATUS, 8'h00);
    $display("test flags done");
    wr(OFS_IRQ0, 8'h01);
    @(posedge ref_clk);
    irq_entry <= 1'b1;
    @(posedge ref_clk);
    irq_entry <= 1'b0;
    @(posedge ref_clk);
    irq_return_instr <= 1'b1;
    #1 `CHK(global_irq_enable, 1'b0)
    @(posedge ref_clk);
    irq_return_instr <= 1'b0;
    @(posedge ref_clk);
    #1 `CHK(global_irq_enable, 1'b1)
    wr(8'h13, 8'h0f);
    #1 `CHK(port_oe[0], 8'hf0)
    rdc(8'h12, 8'hf0);
    wr(8'h1b, 8'h3c);
    #1 `CHK({port_oe[3], port_oe[0]}, 16'hc3f0)
    $display("test irq and port done");
    wr(OFS_WDDIV, 8'hf8);
    rdc(OFS_WDDIV, 8'h00);
    @(posedge ref_clk);
    watchdog_clear_instr <= 1'b1;
    @(posedge ref_clk);
    watchdog_clear_instr <= 1'b0;
    halt_instr <= 1'b1;
    @(posedge ref_clk);
    halt_instr <= 1'b0;
    rdc(OFS_STATUS, 8'h10);
    wr(OFS_BANK, 8'h03);
    wdt_wait();
    rdc(OFS_BANK, 8'h03);
    rdc(OFS_STATUS, 8'h30);
    @(posedge ref_clk);
    watchdog_clear_instr <= 1'b1;
    @(posedge ref_clk);
    watchdog_clear_instr <= 1'b0;
    rdc(OFS_STATUS, 8'h00);
    wr(OFS_WDDIV, 8'h00);
    wr(OFS_BANK, 8'h05);
    wdt_wait();
    rdc(OFS_BANK, 8'h00);
    rdc(OFS_STATUS, 8'h20);
    $display("test watchdog done");
    test_done();
  end
endmodule
